// *** sot_cfg.svh ***
// offsets, field positions, reset values and counts of the
// system option block; assumes inclusion by sot_pkg and sot_top
`ifndef SOT_CFG_SVH
`define SOT_CFG_SVH

// ----------------------------------------------------------------
// register map
// ----------------------------------------------------------------
`define SOT_ADDR_W       8
`define SOT_OFF_OPTIONS  8'h04

// ----------------------------------------------------------------
// field positions of system_options
// ----------------------------------------------------------------
`define SOT_DLY_HI       31
`define SOT_DLY_LO       24
`define SOT_ACT_BIT      23
`define SOT_SEL_HI       22
`define SOT_SEL_LO       20
`define SOT_BUS_CLOCK_OUT_ENABLE_BIT    19
`define SOT_DIV_HI       18
`define SOT_DIV_LO       16
`define SOT_UART_TX_MODULATION_ENABLE_BIT    15
`define SOT_SYNC_BIT     14
`define SOT_RESET_PIN_ENABLE_BIT    2
`define SOT_NMI_PIN_ENABLE_BIT     1

// ----------------------------------------------------------------
// reset values and codes
// ----------------------------------------------------------------
`define SOT_RST_DLY      8'h00
`define SOT_RST_SEL      3'h0
`define SOT_RST_DIV      3'h0
`define SOT_RST_RESET_PIN_ENABLE    1'b1
`define SOT_RST_NMI_PIN_ENABLE     1'b1
`define SOT_SEL_T2_INIT  3'h2
`define SOT_SEL_T2_MATCH 3'h3
`define SOT_PRE_W        7

`endif

// *** sot_pkg.sv ***
// types of the system option and trigger routing block
// assumes sot_cfg.svh on the include path
`include "sot_cfg.svh"

package sot_pkg;

    // ------------------------------------------------------------
    // trigger sources, bit order matches converter_trigger_select
    // ------------------------------------------------------------
    typedef struct packed {
        logic comparator1;
        logic comparator0;
        logic pit_ch1_overflow;
        logic pit_ch0_overflow;
        logic pwm_timer2_match;
        logic pwm_timer2_init;
        logic pwm_timer0_init;
        logic rtc_overflow;
    } sot_trig_src_t;

    // ------------------------------------------------------------
    // delay counter states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        SOT_IDLE  = 2'b01,
        SOT_COUNT = 2'b10
    } sot_dly_st_t;

    // ------------------------------------------------------------
    // whole state of sot_top
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0]            dly_mod;
        logic [2:0]            trig_sel;
        logic                  clk_oe_cfg;
        logic [2:0]            clk_div;
        logic                  tx_mod_en;
        logic                  rst_pin_en;
        logic                  nmi_en;
        logic                  once_lock;
        sot_dly_st_t           st;
        logic [7:0]            cnt;
        logic [`SOT_PRE_W-1:0] pre;
        logic [7:0]            prev;
        logic                  adc_trig;
        logic                  clk_lvl;
        logic                  clk_oe;
        logic                  tx_pin;
        logic                  sync;
        logic                  pready;
        logic                  pslverr;
        logic [31:0]           prdata;
    } sot_state_t;

endpackage

// *** sot_top.sv ***
// system option register with converter trigger routing, trigger
// delay, bus clock output, transmit modulation and pwm sync pulse
// assumes an apb master on pclk; all peer signals are pclk logic
//
// Function
// RL1 - Reset-pin and nmi enable bits accept only the first write after reset.
// RL2 - Bits 31..24 hold the 8-bit delay modulo, 0 to 255 ticks.
// RL3 - The delay counter is one-shot: starts on a timer-2 trigger, stops at the modulo.
// RL4 - The delay counter ticks at the rate chosen by the clock divider field.
// RL5 - Bit 23 reads 1 while a timer-2 trigger is being delayed, else 0.
// RL6 - Bits 22..20 pick one of eight converter trigger sources.
// RL7 - The converter trigger fires only on a rising edge of the source.
// RL8 - Only codes 010 and 011 pass through the delay; others go straight.
// RL9 - Bit 19 enables the bus clock on the clock output pin.
// RL10 - Bits 18..16 divide the output clock by 1, 2, 4 ... 128.
// RL11 - Bit 15 modulates the uart transmit line with timer-0 channel 0.
// RL12 - Writing 1 to bit 14 issues a pwm sync trigger to timer 2.
// RL13 - The sync trigger is one pclk pulse per write of 1.
`timescale 1ns/100ps
`include "sot_cfg.svh"

module sot_top (
    // clock and reset
    input  wire logic                     pclk,
    input  wire logic                     presetn,
    // apb slave
    input  wire logic                     psel,
    input  wire logic                     penable,
    input  wire logic                     pwrite,
    input  wire logic [`SOT_ADDR_W-1:0]   paddr,
    input  wire logic [31:0]              pwdata,
    output logic                          pready,
    output logic                          pslverr,
    output logic [31:0]                   prdata,
    // trigger sources and converter trigger
    input  sot_pkg::sot_trig_src_t        trig_src,
    output logic                          adc_hw_trigger,
    // clock output pin
    output logic                          clock_output_port_pin,
    output logic                          clock_output_oe,
    // uart transmit path
    input  wire logic                     uart_transmit_output,
    input  wire logic                     pwm_timer0_ch0,
    output logic                          uart_tx_pin,
    // timer 2 sync, pin enables and delay status
    output logic                          pwm_sync_request,
    output logic                          reset_pin_enable,
    output logic                          nmi_pin_enable,
    output logic                          trigger_delay_active
);
    import sot_pkg::*;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // low-bit mask of the prescaler for a divider code
    function automatic logic [`SOT_PRE_W-1:0] sot_mask(
        input logic [2:0] code
    );
        logic [7:0] m;
        m = (8'h01 << code) - 8'h01;
        return m[`SOT_PRE_W-1:0];
    endfunction

    // true when the code routes through the delay counter
    function automatic logic sot_is_dly(input logic [2:0] code);
        return (code == `SOT_SEL_T2_INIT) ||
               (code == `SOT_SEL_T2_MATCH);
    endfunction

    localparam sot_state_t SOT_RST = '{
        dly_mod:    `SOT_RST_DLY,
        trig_sel:   `SOT_RST_SEL,
        clk_div:    `SOT_RST_DIV,
        rst_pin_en: `SOT_RST_RESET_PIN_ENABLE,
        nmi_en:     `SOT_RST_NMI_PIN_ENABLE,
        st:         SOT_IDLE,
        default:    '0
    };

    sot_state_t              q;
    sot_state_t              n;
    logic [7:0]              src;
    logic [7:0]              rise;
    logic [31:0]             rd_val;
    logic [`SOT_PRE_W-1:0]   msk;
    logic                    tick;
    logic                    hit;
    logic                    acc;
    logic                    wr;
    logic                    dly_on;
    logic                    dly_edge;
    logic                    fire;

    assign src  = trig_src;
    assign rise = src & ~q.prev;
    assign msk  = sot_mask(q.clk_div);
    assign tick = (q.pre & msk) == msk;
    assign hit  = paddr == `SOT_OFF_OPTIONS;
    assign acc  = psel & penable & ~q.pready;
    assign wr   = psel & penable & q.pready & pwrite & hit;
    assign dly_on   = sot_is_dly(q.trig_sel);
    assign dly_edge = (q.trig_sel == `SOT_SEL_T2_INIT) ?
                      rise[`SOT_SEL_T2_INIT] : rise[`SOT_SEL_T2_MATCH];

    // ------------------------------------------------------------
    // read image
    // ------------------------------------------------------------
    always_comb begin
        rd_val = 32'h0000_0000;
        rd_val[`SOT_DLY_HI:`SOT_DLY_LO] = q.dly_mod;
        rd_val[`SOT_ACT_BIT]            = q.st == SOT_COUNT;
        rd_val[`SOT_SEL_HI:`SOT_SEL_LO] = q.trig_sel;
        rd_val[`SOT_BUS_CLOCK_OUT_ENABLE_BIT]          = q.clk_oe_cfg;
        rd_val[`SOT_DIV_HI:`SOT_DIV_LO] = q.clk_div;
        rd_val[`SOT_UART_TX_MODULATION_ENABLE_BIT]          = q.tx_mod_en;
        rd_val[`SOT_RESET_PIN_ENABLE_BIT]          = q.rst_pin_en;
        rd_val[`SOT_NMI_PIN_ENABLE_BIT]           = q.nmi_en;
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        n      = q;
        fire   = 1'b0;
        n.pre  = q.pre + `SOT_PRE_W'(1);
        n.prev = src;

        // two-cycle apb answer, error on unmapped address
        n.pready  = acc;
        n.pslverr = acc & ~hit;
        n.prdata  = (acc & hit & ~pwrite) ? rd_val : 32'h0000_0000;

        n.sync = 1'b0;
        if (wr) begin
            n.dly_mod    = pwdata[`SOT_DLY_HI:`SOT_DLY_LO]; // RL2
            n.trig_sel   = pwdata[`SOT_SEL_HI:`SOT_SEL_LO]; // RL6
            n.clk_oe_cfg = pwdata[`SOT_BUS_CLOCK_OUT_ENABLE_BIT];
            n.clk_div    = pwdata[`SOT_DIV_HI:`SOT_DIV_LO];
            n.tx_mod_en  = pwdata[`SOT_UART_TX_MODULATION_ENABLE_BIT];
            n.sync       = pwdata[`SOT_SYNC_BIT]; // RL12 RL13
            if (!q.once_lock) begin
                n.rst_pin_en = pwdata[`SOT_RESET_PIN_ENABLE_BIT]; // RL1
                n.nmi_en     = pwdata[`SOT_NMI_PIN_ENABLE_BIT]; // RL1
                n.once_lock  = 1'b1; // RL1
            end
        end

        // one-shot trigger delay
        unique case (q.st)
            SOT_IDLE: begin
                if (dly_on && dly_edge) begin
                    n.cnt = 8'h00;
                    if (q.dly_mod == 8'h00) begin
                        fire = 1'b1;
                    end else begin
                        n.st = SOT_COUNT; // RL3
                    end
                end
            end
            SOT_COUNT: begin
                if (tick) begin // RL4
                    n.cnt = q.cnt + 8'h01;
                    if (n.cnt == q.dly_mod) begin
                        fire = 1'b1;
                        n.st = SOT_IDLE; // RL3
                    end
                end
            end
            default: begin
                n.st = SOT_IDLE;
            end
        endcase

        // converter trigger selection
        n.adc_trig = dly_on ? fire : rise[q.trig_sel]; // RL7 RL8

        // clock output divider
        n.clk_oe  = q.clk_oe_cfg; // RL9
        n.clk_lvl = q.clk_oe_cfg && (q.clk_div != 3'h0) &&
                    n.pre[q.clk_div - 3'h1]; // RL10

        // transmit modulation, carrier fills the low bits
        n.tx_pin = q.tx_mod_en ?
                   (uart_transmit_output | pwm_timer0_ch0) :
                   uart_transmit_output; // RL11
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= SOT_RST;
        end else begin
            q <= n;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign pready               = q.pready;
    assign pslverr              = q.pslverr;
    assign prdata               = q.prdata;
    assign adc_hw_trigger       = q.adc_trig;
    assign clock_output_oe      = q.clk_oe;
    // undivided code gates pclk itself, other codes a flop
    assign clock_output_port_pin = q.clk_oe &
        ((q.clk_div == 3'h0) ? pclk : q.clk_lvl); // RL10
    assign uart_tx_pin          = q.tx_pin;
    assign pwm_sync_request     = q.sync;
    assign reset_pin_enable     = q.rst_pin_en;
    assign nmi_pin_enable       = q.nmi_en;
    assign trigger_delay_active = q.st == SOT_COUNT; // RL5

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_once_lock;
        wr && q.once_lock |=> $stable(reset_pin_enable) &&
                              $stable(nmi_pin_enable);
    endproperty
    a_once_lock: assert property (p_once_lock) // RL1
        else $error("pin enable changed after first write");

    property p_mod_read;
        pready && !pslverr && hit && !pwrite && psel |->
            prdata[`SOT_DLY_HI:`SOT_DLY_LO] == q.dly_mod;
    endproperty
    a_mod_read: assert property (p_mod_read) // RL2
        else $error("delay modulo read back wrong");

    property p_one_shot;
        dly_on && q.st == SOT_COUNT && tick &&
            (q.cnt + 8'h01) == q.dly_mod
            |=> q.st == SOT_IDLE && adc_hw_trigger;
    endproperty
    a_one_shot: assert property (p_one_shot) // RL3
        else $error("delay did not stop at modulo");

    property p_tick_hold;
        q.st == SOT_COUNT && !tick |=> q.cnt == $past(q.cnt);
    endproperty
    a_tick_hold: assert property (p_tick_hold) // RL4
        else $error("delay counter moved without a tick");

    property p_act_set;
        q.st == SOT_IDLE && dly_on && dly_edge && q.dly_mod != 8'h00
            |=> trigger_delay_active && !adc_hw_trigger;
    endproperty
    a_act_set: assert property (p_act_set) // RL5
        else $error("delay active not raised by timer-2 trigger");

    property p_rtc_route;
        q.trig_sel == 3'h0 && rise[0] |=> adc_hw_trigger;
    endproperty
    a_rtc_route: assert property (p_rtc_route) // RL6
        else $error("rtc overflow not routed to converter");

    property p_edge_only;
        !dly_on && src[q.trig_sel] && q.prev[q.trig_sel]
            |=> !adc_hw_trigger;
    endproperty
    a_edge_only: assert property (p_edge_only) // RL7
        else $error("converter trigger on a level");

    property p_direct;
        !dly_on && rise[q.trig_sel] |=> adc_hw_trigger;
    endproperty
    a_direct: assert property (p_direct) // RL8
        else $error("undelayed source lost");

    property p_clk_off;
        !q.clk_oe_cfg |=> !clock_output_oe ##0 !clock_output_port_pin;
    endproperty
    a_clk_off: assert property (p_clk_off) // RL9
        else $error("clock output active while disabled");

    property p_div2;
        q.clk_oe_cfg && q.clk_div == 3'h1 ##1
            q.clk_oe_cfg && q.clk_div == 3'h1
            |=> q.clk_lvl != $past(q.clk_lvl);
    endproperty
    a_div2: assert property (p_div2) // RL10
        else $error("divide by two output did not toggle");

    property p_tx_direct;
        !q.tx_mod_en |=> uart_tx_pin == $past(uart_transmit_output);
    endproperty
    a_tx_direct: assert property (p_tx_direct) // RL11
        else $error("transmit line altered while unmodulated");

    property p_sync_set;
        wr && pwdata[`SOT_SYNC_BIT] |=> pwm_sync_request;
    endproperty
    a_sync_set: assert property (p_sync_set) // RL12
        else $error("sync write gave no pulse");

    property p_sync_pulse;
        pwm_sync_request |=> !pwm_sync_request;
    endproperty
    a_sync_pulse: assert property (p_sync_pulse) // RL13
        else $error("sync pulse longer than one cycle");

    property p_lock_first;
        wr && !q.once_lock |=>
            reset_pin_enable == $past(pwdata[`SOT_RESET_PIN_ENABLE_BIT]) &&
            nmi_pin_enable == $past(pwdata[`SOT_NMI_PIN_ENABLE_BIT]);
    endproperty
    a_lock_first: assert property (p_lock_first) // RL1
        else $error("first pin enable write not taken");

    property p_mod_zero;
        q.st == SOT_IDLE && dly_on && dly_edge && q.dly_mod == 8'h00
            |=> adc_hw_trigger && !trigger_delay_active;
    endproperty
    a_mod_zero: assert property (p_mod_zero) // RL3
        else $error("zero modulo trigger was delayed");

    property p_count_quiet;
        dly_on && q.st == SOT_COUNT && !tick |=> !adc_hw_trigger;
    endproperty
    a_count_quiet: assert property (p_count_quiet) // RL8
        else $error("converter trigger before delay ended");

    property p_oe_on;
        q.clk_oe_cfg |=> clock_output_oe;
    endproperty
    a_oe_on: assert property (p_oe_on) // RL9
        else $error("clock output enable not driven");

    property p_tx_mod;
        q.tx_mod_en |=> uart_tx_pin ==
            ($past(uart_transmit_output) | $past(pwm_timer0_ch0));
    endproperty
    a_tx_mod: assert property (p_tx_mod) // RL11
        else $error("transmit line not modulated");

    property p_sync_none;
        wr && !pwdata[`SOT_SYNC_BIT] |=> !pwm_sync_request;
    endproperty
    a_sync_none: assert property (p_sync_none) // RL12
        else $error("sync pulse without a write of one");

    c_delayed_fire: cover property (
        q.st == SOT_COUNT ##[1:300] adc_hw_trigger);
    c_direct_fire: cover property (
        !dly_on && adc_hw_trigger);
    c_lock_write: cover property (wr && q.once_lock);
    c_sync: cover property (pwm_sync_request);

endmodule

// *** sot_peer.sv ***
// far-side model: trigger sources, uart transmit line, timer-0 carrier
// assumes sot_pkg compiled first; commanded by the bench on pclk
`timescale 1ns/100ps

module sot_peer import sot_pkg::*; (
    // clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // bench command: raise source src for len cycles
    input  wire logic       go,
    input  wire logic [2:0] src,
    input  wire logic [7:0] len,
    // lines into the block
    output sot_trig_src_t   trig_src,
    output logic            uart_tx,
    output logic            ch0
);
    logic [7:0] left_q;
    logic [2:0] src_q;
    logic [7:0] free_q;

    // ------------------------------------------------------------
    // source pulses and free running patterns
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            left_q <= 8'h00;
            src_q  <= 3'h0;
            free_q <= 8'h00;
        end else begin
            free_q <= free_q + 8'h01;
            if (go) begin
                left_q <= len;
                src_q  <= src;
            end else if (left_q != 8'h00) begin
                left_q <= left_q - 8'h01;
            end
        end
    end

    assign trig_src = (left_q != 8'h00) ? sot_trig_src_t'(8'h01 << src_q)
                                        : sot_trig_src_t'(8'h00);
    // carrier toggles every cycle, transmit data every 8
    assign ch0      = free_q[0];
    assign uart_tx  = free_q[3];
endmodule

// *** tb.sv ***
// self-checking bench of sot_top with an apb master task
// assumes sot_pkg, sot_peer and sot_top compiled before it
`timescale 1ns/100ps
`include "sot_cfg.svh"
`define CHK(g, x) begin comparisons++; if ((g) !== (x)) begin \
    err_total++; $display("ERROR %0t: got %h exp %h", $time, g, x); \
    end end

module tb;
    import sot_pkg::*;
    localparam logic [7:0] OFF = `SOT_OFF_OPTIONS;
    logic pclk, presetn, psel, penable, pwrite, go, e, tx_s, ch_s, pv;
    logic [7:0] paddr, len;
    logic [31:0] pwdata, r;
    logic [2:0] src;
    sot_trig_src_t trig_src;
    logic pready, pslverr, adc_hw_trigger, clock_output_port_pin;
    logic clock_output_oe, uart_transmit_output, pwm_timer0_ch0;
    logic uart_tx_pin, pwm_sync_request, reset_pin_enable;
    logic nmi_pin_enable, trigger_delay_active;
    logic [31:0] prdata;
    int err_total, comparisons, cyc, adc_n, adc_t, sync_n, act_n;
    int t0, t1, n0, a0, i, n;

    sot_peer peer_u (.pclk(pclk), .presetn(presetn), .go(go), .src(src),
        .len(len), .trig_src(trig_src), .uart_tx(uart_transmit_output),
        .ch0(pwm_timer0_ch0));
    sot_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
        .prdata(prdata), .trig_src(trig_src),
        .adc_hw_trigger(adc_hw_trigger),
        .clock_output_port_pin(clock_output_port_pin),
        .clock_output_oe(clock_output_oe),
        .uart_transmit_output(uart_transmit_output),
        .pwm_timer0_ch0(pwm_timer0_ch0), .uart_tx_pin(uart_tx_pin),
        .pwm_sync_request(pwm_sync_request),
        .reset_pin_enable(reset_pin_enable),
        .nmi_pin_enable(nmi_pin_enable),
        .trigger_delay_active(trigger_delay_active));

    // ------------------------------------------------------------
    // clock and output monitors
    // ------------------------------------------------------------
    always #5 pclk = ~pclk;
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (adc_hw_trigger === 1'b1) begin
            adc_n <= adc_n + 1;
            adc_t <= cyc;
        end
        if (pwm_sync_request === 1'b1) sync_n <= sync_n + 1;
        if (trigger_delay_active === 1'b1) act_n <= act_n + 1;
    end

    // ------------------------------------------------------------
    // bus and stimulus tasks
    // ------------------------------------------------------------
    task automatic give_verdict();
        $display("comparisons %0d errors %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (k = 0; k < 20; k++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (k < 20) begin
            r = prdata;
            e = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end else begin
            err_total++;
            give_verdict();
        end
    endtask
    task automatic idle(input int c);
        repeat (c) @(posedge pclk);
    endtask
    task automatic fire(input logic [2:0] s, input logic [7:0] l);
        @(posedge pclk);
        go <= 1'b1;
        src <= s;
        len <= l;
        t0 = cyc;
        @(posedge pclk);
        go <= 1'b0;
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_lock();
        apb(0, OFF, 0);
        `CHK(r, 32'h0000_0006)
        `CHK(reset_pin_enable, 1'b1)
        apb(1, OFF, 0);
        apb(1, OFF, 32'h0000_0006);
        idle(2);
        `CHK({reset_pin_enable, nmi_pin_enable}, 2'b00)
        apb(0, 8'h08, 0);
        `CHK({e, r}, {1'b1, 32'h0})
    endtask
    task automatic t_direct();
        int srcs[6] = '{0, 1, 4, 5, 6, 7};
        foreach (srcs[j]) begin
            n = srcs[j];
            apb(1, OFF, 32'h0500_0000 | (n << 20));
            n0 = adc_n;
            fire(3'(n ^ 1), 8'd2);
            idle(8);
            `CHK(adc_n - n0, 0)
            fire(3'(n), 8'd6);
            idle(12);
            `CHK(adc_n - n0, 1)
            `CHK(adc_t - t0, 3)
        end
    endtask
    task automatic t_delay(input int c, m, d, lo, hi, act);
        apb(1, OFF, (m << 24) | (c << 20) | (d << 16));
        n0 = adc_n;
        a0 = act_n;
        fire(3'(c), 8'd2);
        for (i = 0; i < 1200 && adc_n == n0; i++) @(posedge pclk);
        idle(4);
        `CHK(adc_n - n0, 1)
        `CHK(adc_t - t0 >= lo && adc_t - t0 <= hi, 1'b1)
        if (act >= 0) `CHK(act_n - a0, act)
    endtask
    task automatic t_busy();
        apb(1, OFF, 32'h1420_0000);
        n0 = adc_n;
        fire(3'd2, 8'd2);
        t1 = t0;
        idle(4);
        fire(3'd2, 8'd2);
        apb(0, OFF, 0);
        `CHK(r, 32'h14A0_0000)
        idle(30);
        `CHK(adc_n - n0, 1)
        `CHK(adc_t - t1, 23)
        apb(0, OFF, 0);
        `CHK(r, 32'h1420_0000)
    endtask
    task automatic t_clk();
        for (int d = 0; d < 8; d++) begin
            apb(1, OFF, 32'h0008_0000 | (d << 16));
            idle(4);
            `CHK(clock_output_oe, 1'b1)
            @(posedge pclk);
            #1 pv = clock_output_port_pin;
            n = 0;
            for (i = 0; i < 256; i++) begin
                @(posedge pclk);
                #1 if (clock_output_port_pin === 1'b1 && pv === 1'b0) n++;
                pv = clock_output_port_pin;
            end
            if (d == 0) begin
                `CHK(pv, 1'b1)
                @(negedge pclk);
                #1 `CHK(clock_output_port_pin, 1'b0)
            end else `CHK(n, 256 >> d)
        end
        apb(1, OFF, 0);
        idle(4);
        `CHK({clock_output_oe, clock_output_port_pin}, 2'b00)
    endtask
    task automatic t_tx();
        for (int m = 0; m < 2; m++) begin
            apb(1, OFF, m << 15);
            idle(3);
            #1 {tx_s, ch_s} = {uart_transmit_output, pwm_timer0_ch0};
            for (i = 0; i < 32; i++) begin
                @(posedge pclk);
                #1 `CHK(uart_tx_pin, m ? (tx_s | ch_s) : tx_s)
                {tx_s, ch_s} = {uart_transmit_output, pwm_timer0_ch0};
            end
        end
    endtask
    task automatic t_sync();
        n0 = sync_n;
        apb(1, OFF, 32'h0000_4000);
        idle(6);
        `CHK(sync_n - n0, 1)
        apb(0, OFF, 0);
        `CHK(r, 32'h0)
        apb(1, OFF, 0);
        idle(4);
        `CHK(sync_n - n0, 1)
        apb(1, OFF, 32'h0000_4000);
        apb(1, OFF, 32'h0000_4000);
        idle(4);
        `CHK(sync_n - n0, 3)
    endtask
    // mid-run reset reopens the write-once pin enables
    task automatic t_rst();
        presetn <= 1'b0;
        idle(3);
        `CHK({reset_pin_enable, nmi_pin_enable}, 2'b11)
        presetn <= 1'b1;
        apb(1, OFF, 32'h0000_0002);
        apb(1, OFF, 32'h0000_0004);
        idle(2);
        `CHK({reset_pin_enable, nmi_pin_enable}, 2'b01)
    endtask

    initial begin
        {pclk, presetn, psel, penable, pwrite, go} = '0;
        {paddr, pwdata, src, len} = '0;
        {err_total, comparisons, cyc, adc_n, adc_t, sync_n, act_n} = '0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        t_lock();
        t_direct();
        t_delay(2, 0, 0, 3, 3, 0);
        t_delay(3, 255, 0, 258, 258, 255);
        t_delay(2, 3, 2, 11, 16, -1);
        t_busy();
        t_clk();
        t_tx();
        t_sync();
        t_rst();
        give_verdict();
    end
    initial begin
        #1ms;
        err_total++;
        give_verdict();
    end
endmodule
